//--- design/pcarb_top.sv
// How it works
// - mode bit selects internal arbiter (0, reset) or external arbiter with grants idle.
// - with timeout enabled, count 16 idle clocks while granted and FRAME not yet seen.
// - on timeout expiry the grant of the silent requester is removed.
// - refresh off: a broken requester stays excluded from arbitration forever.
// - refresh on: broken state clears once every other enabled requester was served once.
// - eight-bit fairness value, reset 08h, limits hold time while others request.
// - fairness counter reloads from its configured value on every new grant.
// - fairness counter starts decrementing only after the next FRAME falling edge.
// - fairness value zero keeps the grant until its holder drops its request.
// - toggle on: grant drops for one clock two clocks after FRAME asserts.
// - five priority bits, internal requester resets high, external masters low.
// - five enable bits include or exclude each requester, all reset enabled.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pcarb_top
   import pcarb_pkg::*;
#(
   parameter int BMT_LIMIT = BMT_CYCLES
)
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // internal requester
   input  wire logic        int_req,
   output logic             int_gnt,
   // pci bus
   input  wire logic [3:0]  req_n,
   input  wire logic        frame_n,
   input  wire logic        irdy_n,
   output logic      [3:0]  gnt_n,
   output logic             ext_arb_sel
);

   generate
      if (BMT_LIMIT < 2 || BMT_LIMIT > 31) begin : g_bad_limit
         $error("BMT_LIMIT must lie between 2 and 31");
      end
   endgenerate

   typedef struct packed {
      logic [NREQ-1:0]  gnt;
      logic [IDX_W-1:0] last;
      logic [7:0]       fair;
      logic             armed;
      logic             frame_prev;
      logic [4:0]       bmt;
      logic [NREQ-1:0]  broken;
      logic [NREQ-1:0]  served;
      logic [1:0]       tog;
      logic [3:0]       gnt_n;
      logic             int_gnt;
      logic             ext_sel;
   } pcarb_core_s;

   pcarb_core_s q, d;

   pcarb_if bus ();

   logic [NREQ-1:0] req;
   logic [NREQ-1:0] others;
   logic            fall;
   logic            idle;
   logic            holder_req;
   logic            release_g;
   logic            blank;

   // register slave
   pcarb_apb u_apb (
      .ref_clk (ref_clk),
      .rst     (rst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .bus     (bus.regs)
   );

   // winner selection
   pcarb_pick u_pick (
      .bus (bus.pick)
   );

   // requesters seen by the picker
   assign req        = {~req_n, int_req};
   // broken requesters stay out of the eligible set until a refresh clears them
   assign bus.elig   = req & bus.en & ~q.broken;
   assign bus.last   = q.last;
   assign bus.gnt    = q.gnt;
   assign bus.broken = q.broken;

   always_comb begin
      d            = q;
      fall         = q.frame_prev & ~frame_n;
      idle         = frame_n & irdy_n;
      others       = bus.elig & ~q.gnt;
      holder_req   = |(q.gnt & req & bus.en);
      release_g    = 1'b0;
      blank        = 1'b0;
      d.frame_prev = frame_n;
      d.ext_sel    = bus.ext;

      if (bus.ext) begin
         // external arbiter owns the grants
         d.gnt   = '0;
         d.armed = 1'b0;
         d.tog   = 2'h0;
         d.bmt   = 5'h00;
      end else if (q.gnt == '0) begin
         // bus parked idle: issue the next grant
         if (bus.win_vld) begin
            d.gnt    = pcarb_onehot(bus.win);
            d.last   = bus.win;
            d.fair   = bus.fair;
            d.armed  = 1'b0;
            d.bmt    = 5'h00;
            d.tog    = 2'h0;
            d.served = q.served | pcarb_onehot(bus.win);
         end
      end else begin
         // a grant is held
         if (fall) begin
            d.armed = 1'b1;
            if (bus.tog_en && !q.armed) begin
               d.tog = TOG_ARMED;
            end
         end

         // grant toggling
         if (q.tog == TOG_ARMED) begin
            d.tog = TOG_BLANK;
            blank = 1'b1;
         end else if (q.tog == TOG_BLANK) begin
            d.tog = 2'h0;
         end

         // broken master detection
         if (bus.bmt_en && idle && !q.armed) begin
            d.bmt = q.bmt + 5'h01;
            if (q.bmt == 5'(BMT_LIMIT - 1)) begin
               release_g = 1'b1;
               d.broken  = q.broken | q.gnt;
               d.served  = '0;
            end
         end

         // fairness limit while others wait
         if (q.armed && bus.fair != 8'h00 && others != '0) begin
            if (q.fair == 8'h00) begin
               release_g = 1'b1;
            end else begin
               d.fair = q.fair - 8'h01;
            end
         end

         // holder has finished requesting
         if (!holder_req) begin
            release_g = 1'b1;
         end

         if (release_g) begin
            d.gnt   = '0;
            d.armed = 1'b0;
            d.tog   = 2'h0;
            d.bmt   = 5'h00;
            blank   = 1'b0;
         end
      end

      // broken state refresh; a mark set in this same cycle survives the clear
      if (bus.rfsh_en && q.broken != '0 && (&(q.served | q.broken | ~bus.en))) begin
         d.broken = d.broken & ~q.broken;
         d.served = d.served & ~q.served;
      end

      d.gnt_n   = ~d.gnt[NREQ-1:1] | {4{blank}};
      d.int_gnt = d.gnt[0] & ~blank;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q            <= '0;
         q.frame_prev <= 1'b1;
         q.gnt_n      <= 4'hf;
         q.ext_sel    <= EXT_RST;
      end else begin
         q <= d;
      end
   end

   assign gnt_n       = q.gnt_n;
   assign int_gnt     = q.int_gnt;
   assign ext_arb_sel = q.ext_sel;

endmodule

`default_nettype wire

//--- design/pcarb_pkg.sv
package pcarb_pkg;

   // requesters: index 0 is the internal requester, 1 to 4 the external masters
   localparam int          NREQ        = 5;
   localparam int          IDX_W       = 3;

   // register byte addresses
   localparam logic [11:0] MODE_OFS    = 12'h048;
   localparam logic [11:0] STAT_OFS    = 12'h080;

   // mode word field positions
   localparam int          EN_LSB      = 0;
   localparam int          EXT_BIT     = 9;
   localparam int          BMT_BIT     = 10;
   localparam int          RFSH_BIT    = 11;
   localparam int          FAIR_LSB    = 12;
   localparam int          TOG_BIT     = 20;
   localparam int          PRIO_LSB    = 22;

   // status word field positions
   localparam int          GNT_LSB     = 0;
   localparam int          BRK_LSB     = 8;

   // reset values
   localparam logic [4:0]  EN_RST      = 5'h1f;
   localparam logic        EXT_RST     = 1'b0;
   localparam logic        BMT_RST     = 1'b0;
   localparam logic        RFSH_RST    = 1'b0;
   localparam logic [7:0]  FAIR_RST    = 8'h08;
   localparam logic        TOG_RST     = 1'b0;
   localparam logic [4:0]  PRIO_RST    = 5'h01;

   // timing count in bus clocks, then grant toggle state codes
   localparam int          BMT_CYCLES  = 16;
   localparam logic [1:0]  TOG_ARMED   = 2'h1;
   localparam logic [1:0]  TOG_BLANK   = 2'h2;

   function automatic logic [NREQ-1:0] pcarb_onehot(input logic [IDX_W-1:0] idx);
      pcarb_onehot = NREQ'(1) << idx;
   endfunction

endpackage

//--- design/pcarb_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pcarb_if
   import pcarb_pkg::*;
   ();
   // configuration from the register slave
   logic [NREQ-1:0]  en;
   logic             ext;
   logic             bmt_en;
   logic             rfsh_en;
   logic [7:0]       fair;
   logic             tog_en;
   logic [NREQ-1:0]  prio;
   // state shown back to software
   logic [NREQ-1:0]  gnt;
   logic [NREQ-1:0]  broken;
   // picker request and answer
   logic [NREQ-1:0]  elig;
   logic [IDX_W-1:0] last;
   logic [IDX_W-1:0] win;
   logic             win_vld;

   modport regs (output en, ext, bmt_en, rfsh_en, fair, tog_en, prio,
                 input  gnt, broken);
   modport core (input  en, ext, bmt_en, rfsh_en, fair, tog_en, prio, win, win_vld,
                 output gnt, broken, elig, last);
   modport pick (input  elig, last, prio,
                 output win, win_vld);
endinterface

`default_nettype wire

//--- design/pcarb_pick.sv
`timescale 1ns/1ps
`default_nettype none

module pcarb_pick
   import pcarb_pkg::*;
(
   // picker side of the shared bundle
   pcarb_if.pick bus
);

   logic [NREQ-1:0]  set;
   logic [IDX_W-1:0] idx;

   // high priority first, then round robin after the last winner
   always_comb begin
      set         = (|(bus.elig & bus.prio)) ? (bus.elig & bus.prio) : bus.elig;
      bus.win     = '0;
      bus.win_vld = 1'b0;
      idx         = '0;
      for (int i = NREQ; i >= 1; i--) begin
         idx = IDX_W'((int'(bus.last) + i) % NREQ);
         if (set[idx]) begin
            bus.win     = idx;
            bus.win_vld = 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

//--- design/pcarb_apb.sv
`timescale 1ns/1ps
`default_nettype none

module pcarb_apb
   import pcarb_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // configuration and status
   pcarb_if.regs            bus
);

   typedef struct packed {
      logic [NREQ-1:0] en;
      logic            ext;
      logic            bmt_en;
      logic            rfsh_en;
      logic [7:0]      fair;
      logic            tog_en;
      logic [NREQ-1:0] prio;
      logic [31:0]     rdata;
      logic            rdy;
      logic            err;
   } pcarb_apb_s;

   pcarb_apb_s q, d;

   function automatic logic [31:0] mode_word(input pcarb_apb_s s);
      mode_word                         = 32'h0000_0000;
      mode_word[EN_LSB +: NREQ]         = s.en;
      mode_word[EXT_BIT]                = s.ext;
      mode_word[BMT_BIT]                = s.bmt_en;
      mode_word[RFSH_BIT]               = s.rfsh_en;
      mode_word[FAIR_LSB +: 8]          = s.fair;
      mode_word[TOG_BIT]                = s.tog_en;
      mode_word[PRIO_LSB +: NREQ]       = s.prio;
   endfunction

   always_comb begin
      d     = q;
      d.rdy = psel & ~penable;
      d.err = psel & ~penable & (paddr != MODE_OFS) & (paddr != STAT_OFS);
      if (psel & ~penable) begin
         d.rdata = 32'h0000_0000;
         if (paddr == MODE_OFS) begin
            d.rdata = mode_word(q);
         end else if (paddr == STAT_OFS) begin
            d.rdata[GNT_LSB +: NREQ] = bus.gnt;
            d.rdata[BRK_LSB +: NREQ] = bus.broken;
         end
      end
      if (psel & penable & q.rdy & pwrite & (paddr == MODE_OFS)) begin
         d.en      = pwdata[EN_LSB +: NREQ];
         d.ext     = pwdata[EXT_BIT];
         d.bmt_en  = pwdata[BMT_BIT];
         d.rfsh_en = pwdata[RFSH_BIT];
         d.fair    = pwdata[FAIR_LSB +: 8];
         d.tog_en  = pwdata[TOG_BIT];
         d.prio    = pwdata[PRIO_LSB +: NREQ];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q         <= '0;
         q.en      <= EN_RST;
         q.ext     <= EXT_RST;
         q.bmt_en  <= BMT_RST;
         q.rfsh_en <= RFSH_RST;
         q.fair    <= FAIR_RST;
         q.tog_en  <= TOG_RST;
         q.prio    <= PRIO_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata      = q.rdata;
   assign pready      = q.rdy;
   assign pslverr     = q.err;
   assign bus.en      = q.en;
   assign bus.ext     = q.ext;
   assign bus.bmt_en  = q.bmt_en;
   assign bus.rfsh_en = q.rfsh_en;
   assign bus.fair    = q.fair;
   assign bus.tog_en  = q.tog_en;
   assign bus.prio    = q.prio;

endmodule

`default_nettype wire

//--- testbench/pcarb_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pcarb_chk
   import pcarb_pkg::*;
#(
   parameter int BMT_LIMIT = BMT_CYCLES
)
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // arbitration
   input wire logic        int_req,
   input wire logic        int_gnt,
   input wire logic [3:0]  req_n,
   input wire logic        frame_n,
   input wire logic        irdy_n,
   input wire logic [3:0]  gnt_n,
   input wire logic        ext_arb_sel
);
   logic [31:0] m_q;
   logic [5:0]  c_q;
   logic [8:0]  w_q;
   logic        calm;
   assign calm = !m_q[9] && !m_q[10] && !m_q[20] && m_q[1];
   // shadow of the mode word, idle count and fairness wait of master 1
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         m_q <= 32'h0040_801f;
         c_q <= 6'h00;
         w_q <= 9'h000;
      end else begin
         if (psel && penable && pready && pwrite && paddr == MODE_OFS) begin
            m_q <= pwdata;
         end
         if (gnt_n[0]) begin
            c_q <= 6'h00;
            w_q <= 9'h000;
         end else begin
            if (!frame_n) begin
               c_q <= 6'h3f;
            end else if (irdy_n && c_q != 6'h3f) begin
               c_q <= c_q + 6'h01;
            end
            if (c_q == 6'h3f && (!(&req_n[3:1]) || int_req)) begin
               w_q <= w_q + 9'h001;
            end
         end
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_blip;
      ##2 (gnt_n[0] == m_q[20]) ##1 !gnt_n[0];
   endsequence
   a_one_grant: assert property ($onehot0({~gnt_n, int_gnt}))
      else $error("more than one grant");
   a_ext_idle: assert property (ext_arb_sel |-> gnt_n == 4'hf && !int_gnt)
      else $error("grant while external arbiter");
   a_ext_sel: assert property (m_q[9] |-> ##[1:2] ext_arb_sel)
      else $error("external select missing");
   a_bmt_limit: assert property (m_q[10] && c_q != 6'h3f |-> c_q <= BMT_LIMIT + 1)
      else $error("idle grant held too long");
   a_drop_release: assert property (!gnt_n[0] && req_n[0] |-> ##[1:2] gnt_n[0])
      else $error("grant kept without request");
   a_fair_zero: assert property (m_q[19:12] == 8'h00 && calm && !gnt_n[0] && !req_n[0]
      |=> !gnt_n[0])
      else $error("grant removed with fairness zero");
   a_fair_limit: assert property (m_q[19:12] != 8'h00
      |-> w_q <= {1'b0, m_q[19:12]} + 9'h004)
      else $error("fairness limit exceeded");
   a_tog_blip: assert property (!gnt_n[0] && $fell(frame_n) |-> s_blip)
      else $error("grant toggle wrong");
   a_fair_armed: assert property (calm && !gnt_n[0] && !req_n[0]
      && c_q != 6'h3f |=> !gnt_n[0])
      else $error("grant removed before frame");
   a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle");
   a_bad_addr: assert property (psel && !penable && paddr != MODE_OFS && paddr != STAT_OFS
      |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
endmodule
bind pcarb_top pcarb_chk #(.BMT_LIMIT(BMT_LIMIT)) u_chk (.ref_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .int_req, .int_gnt, .req_n,
   .frame_n, .irdy_n, .gnt_n, .ext_arb_sel);
`default_nettype wire

//--- testbench/pcarb_masters.sv
`timescale 1ns/1ps
`default_nettype none
module pcarb_masters (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // bench controls
   input  wire logic [4:0] want,
   input  wire logic [4:0] mute,
   input  wire logic [7:0] len,
   // bus side
   input  wire logic [4:0] gnt,
   output logic      [4:0] req,
   output logic            frame_n,
   output logic            irdy_n
);
   logic [4:0] done;
   logic [7:0] cnt;
   logic [2:0] own;
   logic       busy;
   // one transaction per request, request dropped once it ends
   assign req = want & ~done;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy    <= 1'b0;
         frame_n <= 1'b1;
         irdy_n  <= 1'b1;
         done    <= 5'h00;
      end else if (busy) begin
         irdy_n <= 1'b0;
         cnt    <= cnt - 8'h01;
         if (cnt == 8'h00) begin
            busy      <= 1'b0;
            frame_n   <= 1'b1;
            irdy_n    <= 1'b1;
            done[own] <= 1'b1;
         end
      end else begin
         done <= done & want;
         for (int i = 0; i < 5; i++) begin
            if (gnt[i] && req[i] && !mute[i]) begin
               busy    <= 1'b1;
               frame_n <= 1'b0;
               cnt     <= len;
               own     <= 3'(i);
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import pcarb_pkg::*;
;
   localparam int          BMT = 16;
   localparam logic [31:0] D   = 32'h0040_801f;
   logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic        int_req, int_gnt, frame_n, irdy_n, ext_arb_sel, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  req_n, gnt_n;
   logic [4:0]  want, mute, q, g;
   logic [7:0]  len;
   int          fail_count, tests_run;
   pcarb_top #(.BMT_LIMIT(BMT)) u_dut (.ref_clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .int_req, .int_gnt, .req_n,
      .frame_n, .irdy_n, .gnt_n, .ext_arb_sel);
   pcarb_masters u_mst (.ref_clk, .rst, .want, .mute, .len, .gnt(g), .req(q),
      .frame_n, .irdy_n);
   assign g       = {~gnt_n, int_gnt};
   assign int_req = q[0];
   assign req_n   = ~q[4:1];
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic end_sim;
      if (fail_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic seq(input logic [4:0] w, input logic [14:0] ex);
      logic [2:0] e;
      want <= w;
      for (int k = 0; k < 5; k++) begin
         e = ex[k*3+:3];
         if (e != 3'h7) begin
            do @(posedge ref_clk); while (g === 5'h00);
            chk("gnt", 32'(g), 32'(5'h01 << e));
            do @(posedge ref_clk); while (g !== 5'h00);
         end
      end
      repeat (30) @(posedge ref_clk);
      chk("idle", 32'(g), 32'h0);
      want <= 5'h00;
      @(posedge ref_clk);
   endtask
   task automatic t_regs;
      apb(1'b0, MODE_OFS, 32'h0);
      chk("ext", 32'(rd[9]), 32'h0);
      chk("fair", 32'(rd[19:12]), 32'h8);
      chk("tog", 32'(rd[20]), 32'h0);
      chk("prio", 32'(rd[26:22]), 32'h1);
      chk("en", 32'(rd[4:0]), 32'h1f);
      apb(1'b1, MODE_OFS, 32'hffff_ffff);
      apb(1'b0, MODE_OFS, 32'h0);
      chk("mode", rd, 32'h07df_fe1f);
      apb(1'b0, 12'h04c, 32'h0);
      chk("err", 32'(er), 32'h1);
      apb(1'b1, MODE_OFS, D);
   endtask
   task automatic t_bmt;
      int c;
      apb(1'b1, MODE_OFS, D | 32'h0000_0400);
      mute <= 5'h02;
      want <= 5'h02;
      do @(posedge ref_clk); while (g[1] !== 1'b1);
      c = 0;
      while (g[1] === 1'b1) begin
         @(posedge ref_clk);
         c++;
      end
      chk("bmt", 32'(c >= BMT - 1 && c <= BMT + 2), 32'h1);
      want <= 5'h00;
      mute <= 5'h00;
      apb(1'b0, STAT_OFS, 32'h0);
      chk("brk", 32'(rd[12:8]), 32'h2);
      seq(5'h02, 15'h7fff);
      apb(1'b1, MODE_OFS, D | 32'h0000_0c00);
      seq(5'h1d, {3'h7, 3'h4, 3'h3, 3'h2, 3'h0});
      apb(1'b0, STAT_OFS, 32'h0);
      chk("brk", 32'(rd[12:8]), 32'h0);
      seq(5'h02, {3'h7, 3'h7, 3'h7, 3'h7, 3'h1});
   endtask
   task automatic t_fair(input logic [7:0] f);
      int c;
      apb(1'b1, MODE_OFS, {D[31:20], f, D[11:0]});
      len  <= 8'h3c;
      want <= 5'h02;
      do @(posedge ref_clk); while (g[1] !== 1'b1);
      want <= 5'h06;
      c = 0;
      while (g[1] === 1'b1) begin
         @(posedge ref_clk);
         c++;
      end
      chk("fair", 32'(c < 30), 32'(f != 8'h00));
      repeat (150) @(posedge ref_clk);
      want <= 5'h00;
      len  <= 8'h08;
      @(posedge ref_clk);
   endtask
   task automatic t_tog(input logic t, input logic [31:0] n);
      int   c;
      logic p;
      apb(1'b1, MODE_OFS, D | (32'(t) << TOG_BIT));
      want <= 5'h02;
      c = 0;
      p = 1'b0;
      repeat (40) begin
         @(posedge ref_clk);
         if (g[1] === 1'b1 && p !== 1'b1) c++;
         p = g[1];
      end
      chk("tog", 32'(c), n);
      want <= 5'h00;
      @(posedge ref_clk);
   endtask
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; want = 5'h00; mute = 5'h00; len = 8'h08;
      fail_count = 0;
      tests_run = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_regs;
      seq(5'h1f, {3'h4, 3'h3, 3'h2, 3'h1, 3'h0});
      apb(1'b1, MODE_OFS, 32'h0200_801f);
      seq(5'h1f, {3'h2, 3'h1, 3'h0, 3'h4, 3'h3});
      apb(1'b1, MODE_OFS, 32'h0040_801b);
      seq(5'h06, {3'h7, 3'h7, 3'h7, 3'h7, 3'h1});
      apb(1'b1, MODE_OFS, D | 32'h0000_0200);
      seq(5'h02, 15'h7fff);
      chk("sel", 32'(ext_arb_sel), 32'h1);
      t_tog(1'b0, 32'h1);
      t_tog(1'b1, 32'h2);
      t_fair(8'h04);
      t_fair(8'h00);
      t_bmt;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      end_sim;
   end
endmodule
`default_nettype wire
